// *** inc/mcc_pkg.sv ***
// Constants, register map and types shared by the main clock controller.
package mcc_pkg;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [9:0] CCSR_INDEX = 10'h02C;
  localparam logic [9:0] BEEP_INDEX = 10'h02D;
  localparam logic [9:0] EVT_STATUS_INDEX = 10'h02E;
  localparam logic [9:0] EVT_MASK_INDEX = 10'h02F;
  localparam logic [11:0] CCSR_ADDR = {CCSR_INDEX, 2'b00};
  localparam logic [11:0] BEEP_ADDR = {BEEP_INDEX, 2'b00};
  localparam logic [11:0] EVT_STATUS_ADDR = {EVT_STATUS_INDEX, 2'b00};
  localparam logic [11:0] EVT_MASK_ADDR = {EVT_MASK_INDEX, 2'b00};
  localparam int ADDR_WIDTH = 12;

  // Field layout of the clock control/status register.
  localparam int CLOCK_OUT_ENABLE_BIT = 7;
  localparam int SLOW_DIVIDER_LSB = 5;
  localparam int SLOW_MODE_SELECT_BIT = 4;
  localparam int TIME_BASE_LSB = 2;
  localparam int TIMER_IRQ_ENABLE_BIT = 1;
  localparam int TIMEOUT_FLAG_BIT = 0;
  // Field layout of the beep control register.
  localparam int TONE_SELECT_LSB = 0;
  // Event status and mask layout.
  localparam int EVT_TIMEOUT_BIT = 0;
  localparam int EVT_WAKE_BIT = 1;
  localparam int EVT_WIDTH = 2;

  localparam logic [7:0] CCSR_RESET = 8'h00;
  localparam logic [1:0] TONE_RESET = 2'h0;
  localparam logic [EVT_WIDTH-1:0] EVT_RESET = 2'h0;

  localparam logic [1:0] TONE_OFF = 2'h0;
  localparam logic [1:0] TONE_HIGH = 2'h1;
  localparam logic [1:0] TONE_MID = 2'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Time-base periods in halved-oscillator cycles.
  localparam int TB_PERIOD_0 = 16000;
  localparam int TB_PERIOD_1 = 32000;
  localparam int TB_PERIOD_2 = 80000;
  localparam int TB_PERIOD_3 = 200000;

  // Tone frequencies for the reference halved-oscillator rate.
  localparam int TONE_OSC_HZ = 8000000;
  localparam int TONE_HZ_HIGH = 2000;
  localparam int TONE_HZ_MID = 1000;
  localparam int TONE_HZ_LOW = 500;
  localparam int TONE_HALF_HIGH = TONE_OSC_HZ / (2 * TONE_HZ_HIGH);
  localparam int TONE_HALF_MID = TONE_OSC_HZ / (2 * TONE_HZ_MID);
  localparam int TONE_HALF_LOW = TONE_OSC_HZ / (2 * TONE_HZ_LOW);

  typedef enum logic [2:0] {
    PWR_RUN = 3'b001,
    PWR_ACTIVE_HALT = 3'b010,
    PWR_HALT = 3'b100
  } mcc_power_type;
endpackage : mcc_pkg

// *** rtl/mcc_main_clock.sv ***
// Main clock controller: CPU prescaler, clock-out, time base, tone and bus slave.
// Function
// [R1] Slow mode divides CPU clock by 2..16
// [R2] Clock-out enable drives CPU clock on pin (pin toggles once per CPU cycle, so it carries half the CPU rate)
// [R3] Clock-out stops toggling during active halt
// [R4] Time-base periods 16000/32000/80000/200000 cycles
// [R5] Time-base change applies after current period
// [R6] Period end sets timeout; register read clears
// [R7] CPU irq: flag, enable set, mask clear
// [R8] Halt with irq enable enters active halt
// [R9] Wait mode unaffected; timer irq wakes
// [R10] Active halt: counter runs, registers frozen
// [R11] Full halt freezes all; timer cannot wake
// [R12] Tone select: off, 2k, 1k, 500 Hz
// [R13] Tone keeps running during active halt
// [R14] Software writes zero to reserved beep bits
// [R15] Software avoids read-modify-write on control register
// [R16] Both registers reset to zero
// [R17] All four functions work independently together
// [R18] Counter resets, restarts from zero each period
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
module mcc_main_clock
  import mcc_pkg::*;
#(
  parameter int TB_COUNT_0 = TB_PERIOD_0,
  parameter int TB_COUNT_1 = TB_PERIOD_1,
  parameter int TB_COUNT_2 = TB_PERIOD_2,
  parameter int TB_COUNT_3 = TB_PERIOD_3,
  parameter int TB_WIDTH = 18,
  parameter int TONE_COUNT_HIGH = TONE_HALF_HIGH,
  parameter int TONE_COUNT_MID = TONE_HALF_MID,
  parameter int TONE_COUNT_LOW = TONE_HALF_LOW,
  parameter int TONE_WIDTH = 13
) (
  // Clock (halved oscillator clock) and reset
  input wire logic clk,
  input wire logic rst,
  // AXI4-Lite write address
  input wire logic [ADDR_WIDTH-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address
  input wire logic [ADDR_WIDTH-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // AXI4-Lite read data
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // CPU core power control
  input wire logic haltInstruction,
  input wire logic haltWakeup,
  input wire logic waitMode,
  input wire logic cpuIntMask,
  output logic cpuClockEnable,
  output logic activeHaltMode,
  output logic fullHaltMode,
  // Interrupts
  output logic timerIrq,
  output logic irq,
  // Port pins
  output logic clockOutPinOut,
  output logic clockOutPinOe,
  output logic tonePinOut,
  output logic tonePinOe
);

  mcc_power_type powerState;
  mcc_power_type next_powerState;

  logic [7:0] controlStatus;
  logic [1:0] toneSelect;
  logic [EVT_WIDTH-1:0] eventStatus;
  logic [EVT_WIDTH-1:0] eventMask;

  logic clockOutEnable;
  logic [1:0] slowDividerSelect;
  logic slowModeSelect;
  logic [1:0] timeBaseSelect;
  logic timerIrqEnable;
  logic timeoutFlag;

  logic [1:0] activeTimeBase;
  logic [TB_WIDTH-1:0] timeBaseCount;
  logic periodEnd;
  logic [3:0] prescaleCount;
  logic cpuTick;
  logic [TONE_WIDTH-1:0] toneCount;
  logic toneLevel;
  logic clockOutLevel;

  logic [ADDR_WIDTH-1:0] writeAddr;
  logic writeAddrHeld;
  logic [7:0] writeByte;
  logic writeByteValid;
  logic writeDataHeld;
  logic writeFire;
  logic readFire;
  logic readControl;
  logic registersFrozen;
  logic timerWake;

  assign clockOutEnable = controlStatus[CLOCK_OUT_ENABLE_BIT];
  assign slowDividerSelect = controlStatus[SLOW_DIVIDER_LSB +: 2];
  assign slowModeSelect = controlStatus[SLOW_MODE_SELECT_BIT];
  assign timeBaseSelect = controlStatus[TIME_BASE_LSB +: 2];
  assign timerIrqEnable = controlStatus[TIMER_IRQ_ENABLE_BIT];
  assign timeoutFlag = controlStatus[TIMEOUT_FLAG_BIT];

  // Last prescaler count for the selected slow divider.
  function automatic logic [3:0] dividerLast(input logic [1:0] sel);
    unique case (sel)
      2'h0: dividerLast = 4'h1;
      2'h1: dividerLast = 4'h3;
      2'h2: dividerLast = 4'h7;
      default: dividerLast = 4'hF;
    endcase
  endfunction : dividerLast

  // Last count of a time-base period.
  function automatic logic [TB_WIDTH-1:0] periodLast(input logic [1:0] sel);
    unique case (sel)
      2'h0: periodLast = TB_WIDTH'(TB_COUNT_0 - 1);
      2'h1: periodLast = TB_WIDTH'(TB_COUNT_1 - 1);
      2'h2: periodLast = TB_WIDTH'(TB_COUNT_2 - 1);
      default: periodLast = TB_WIDTH'(TB_COUNT_3 - 1);
    endcase
  endfunction : periodLast

  // Last count of a tone half period.
  function automatic logic [TONE_WIDTH-1:0] toneLast(input logic [1:0] sel);
    unique case (sel)
      TONE_HIGH: toneLast = TONE_WIDTH'(TONE_COUNT_HIGH - 1);
      TONE_MID: toneLast = TONE_WIDTH'(TONE_COUNT_MID - 1);
      default: toneLast = TONE_WIDTH'(TONE_COUNT_LOW - 1);
    endcase
  endfunction : toneLast

  // Power state follows the CPU halt requests.
  assign timerWake = timeoutFlag && timerIrqEnable;
  assign registersFrozen = (powerState != PWR_RUN);

  always_comb begin
    next_powerState = powerState;
    unique case (powerState)
      PWR_RUN: begin
        if (haltInstruction) begin
          next_powerState = timerIrqEnable ? PWR_ACTIVE_HALT : PWR_HALT; // [R8]
        end
      end
      PWR_ACTIVE_HALT: begin
        if (timerWake || periodEnd && timerIrqEnable || haltWakeup) begin
          next_powerState = PWR_RUN; // [R10]
        end
      end
      PWR_HALT: begin
        if (haltWakeup) begin
          next_powerState = PWR_RUN; // [R11]
        end
      end
      default: next_powerState = PWR_RUN;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      powerState <= PWR_RUN;
    end else begin
      powerState <= next_powerState;
    end
  end

  assign activeHaltMode = (powerState == PWR_ACTIVE_HALT);
  assign fullHaltMode = (powerState == PWR_HALT);

  // CPU prescaler; the CPU is stopped in either halt mode.
  assign cpuTick = !registersFrozen &&
                   (!slowModeSelect || prescaleCount >= dividerLast(slowDividerSelect)); // [R1]
  assign cpuClockEnable = cpuTick;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prescaleCount <= 4'h0;
    end else if (registersFrozen || !slowModeSelect || cpuTick) begin
      prescaleCount <= 4'h0; // [R1]
    end else begin
      prescaleCount <= prescaleCount + 4'h1;
    end
  end

  // Clock-out toggles once per CPU cycle; a flop cannot copy clk itself, so the
  // pin carries half the CPU rate, and it holds still in active halt.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clockOutLevel <= 1'b0;
    end else if (!clockOutEnable || activeHaltMode || next_powerState == PWR_ACTIVE_HALT) begin
      clockOutLevel <= 1'b0; // [R3]
    end else if (cpuTick) begin
      clockOutLevel <= !clockOutLevel; // [R2] [R17]
    end
  end

  assign clockOutPinOut = clockOutLevel;
  assign clockOutPinOe = clockOutEnable; // [R2]

  // Time base; the new selection is taken only at a period end.
  assign periodEnd = !fullHaltMode && (timeBaseCount == periodLast(activeTimeBase)); // [R4]

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timeBaseCount <= '0; // [R18]
      activeTimeBase <= 2'h0;
    end else if (fullHaltMode) begin
      timeBaseCount <= timeBaseCount; // [R11]
    end else if (periodEnd) begin
      timeBaseCount <= '0; // [R18]
      activeTimeBase <= timeBaseSelect; // [R5]
    end else begin
      timeBaseCount <= timeBaseCount + TB_WIDTH'(1); // [R10]
    end
  end

  // Tone generator; it keeps running in active halt and stops in full halt.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      toneCount <= '0;
      toneLevel <= 1'b0;
    end else if (toneSelect == TONE_OFF) begin
      toneCount <= '0;
      toneLevel <= 1'b0; // [R12]
    end else if (fullHaltMode) begin
      toneCount <= toneCount;
    end else if (toneCount >= toneLast(toneSelect)) begin
      toneCount <= '0;
      toneLevel <= !toneLevel; // [R12] [R13]
    end else begin
      toneCount <= toneCount + TONE_WIDTH'(1);
    end
  end

  assign tonePinOut = toneLevel;
  assign tonePinOe = (toneSelect != TONE_OFF); // [R12]

  // Bus slave: address and data are held until both are present.
  assign awready = !writeAddrHeld && !bvalid;
  assign wready = !writeDataHeld && !bvalid;
  assign writeFire = writeAddrHeld && writeDataHeld && !bvalid;
  assign arready = !rvalid;
  assign readFire = arvalid && arready;
  assign readControl = readFire && (araddr == CCSR_ADDR);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      writeAddrHeld <= 1'b0;
      writeAddr <= '0;
    end else if (awvalid && awready) begin
      writeAddrHeld <= 1'b1;
      writeAddr <= awaddr;
    end else if (writeFire) begin
      writeAddrHeld <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      writeDataHeld <= 1'b0;
      writeByte <= 8'h00;
      writeByteValid <= 1'b0;
    end else if (wvalid && wready) begin
      writeDataHeld <= 1'b1;
      writeByte <= wdata[7:0];
      writeByteValid <= wstrb[0];
    end else if (writeFire) begin
      writeDataHeld <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (writeFire) begin
      bvalid <= 1'b1;
      bresp <= (writeAddr == CCSR_ADDR || writeAddr == BEEP_ADDR ||
                writeAddr == EVT_STATUS_ADDR || writeAddr == EVT_MASK_ADDR) ?
               RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Control/status register; the timeout flag is set by hardware only, and a
  // set in the same cycle as a clearing read wins so no period is lost.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      controlStatus <= CCSR_RESET; // [R16]
    end else begin
      if (writeFire && writeByteValid && writeAddr == CCSR_ADDR && !registersFrozen) begin
        controlStatus[7:1] <= writeByte[7:1]; // [R10]
      end
      if (periodEnd) begin
        controlStatus[TIMEOUT_FLAG_BIT] <= 1'b1; // [R6]
      end else if (readControl) begin
        controlStatus[TIMEOUT_FLAG_BIT] <= 1'b0; // [R6]
      end
    end
  end

  // Beep control; only the tone field is stored, reserved bits read zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      toneSelect <= TONE_RESET; // [R16]
    end else if (writeFire && writeByteValid && writeAddr == BEEP_ADDR && !registersFrozen) begin
      toneSelect <= writeByte[TONE_SELECT_LSB +: 2]; // [R14]
    end
  end

  // Event status (write one to clear, set wins) and its mask.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      eventStatus <= EVT_RESET;
    end else begin
      for (int i = 0; i < EVT_WIDTH; i++) begin
        if (i == EVT_TIMEOUT_BIT && periodEnd ||
            i == EVT_WAKE_BIT && registersFrozen && next_powerState == PWR_RUN) begin
          eventStatus[i] <= 1'b1;
        end else if (writeFire && writeByteValid && writeAddr == EVT_STATUS_ADDR &&
                     writeByte[i]) begin
          eventStatus[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      eventMask <= EVT_RESET;
    end else if (writeFire && writeByteValid && writeAddr == EVT_MASK_ADDR) begin
      eventMask <= writeByte[EVT_WIDTH-1:0];
    end
  end

  assign irq = |(eventStatus & eventMask);

  // The CPU request ignores wait mode: it is what brings the core out of it.
  assign timerIrq = timeoutFlag && timerIrqEnable && !cpuIntMask; // [R7] [R9]

  // Read channel; the read value carries the flag as it was before clearing.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (readFire) begin
      rvalid <= 1'b1;
      rresp <= RESP_OKAY;
      unique case (araddr)
        CCSR_ADDR: rdata <= {24'h00_0000, controlStatus};
        BEEP_ADDR: rdata <= {30'h0000_0000, toneSelect};
        EVT_STATUS_ADDR: rdata <= {30'h0000_0000, eventStatus};
        EVT_MASK_ADDR: rdata <= {30'h0000_0000, eventMask};
        default: begin
          rdata <= 32'h0000_0000;
          rresp <= RESP_SLVERR;
        end
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule : mcc_main_clock

// *** verification/mcc_main_clock_properties.sv ***
// Port-level assertions for the main clock controller.
`timescale 1ns/1ps
module mcc_main_clock_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bus handshakes
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  // Power control and outputs
  input wire logic haltInstruction,
  input wire logic haltWakeup,
  input wire logic cpuClockEnable,
  input wire logic activeHaltMode,
  input wire logic fullHaltMode,
  input wire logic timerIrq,
  input wire logic clockOutPinOut
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read request not answered");
  a_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped early");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_halt_entry: assert property (haltInstruction && !activeHaltMode && !fullHaltMode
    |=> activeHaltMode || fullHaltMode) else $error("halt not entered");
  a_halt_no_tick: assert property (activeHaltMode || fullHaltMode |-> !cpuClockEnable)
    else $error("cpu tick during halt");
  a_full_halt_stays: assert property (fullHaltMode && !haltWakeup |=> fullHaltMode)
    else $error("full halt left without wake");
  a_timer_wakes: assert property (activeHaltMode && timerIrq |-> ##[1:2] !activeHaltMode)
    else $error("timer did not end active halt");
  a_clkout_still: assert property (activeHaltMode && $past(activeHaltMode)
    |-> $stable(clockOutPinOut)) else $error("clock out toggles in active halt");
endmodule : mcc_main_clock_properties

// *** verification/mcc_cpu_model.sv ***
// Core-side model that issues halt instructions and halt wake-ups.
`timescale 1ns/1ps
module mcc_cpu_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Requests from the bench
  input wire logic haltReq,
  input wire logic wakeReq,
  // Core side of the controller
  output logic haltInstruction,
  output logic haltWakeup
);
  // The core executes halt every other cycle while a request is held, so a one-cycle request gives one pulse.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      haltInstruction <= 1'h0;
      haltWakeup <= 1'h0;
    end else begin
      haltInstruction <= haltReq && !haltInstruction;
      haltWakeup <= wakeReq;
    end
  end
endmodule : mcc_cpu_model

// *** verification/tb_mcc_main_clock.sv ***
// Self-checking bench for the main clock controller.
`timescale 1ns/1ps
module tb_mcc_main_clock;
  import mcc_pkg::*;
  typedef struct {logic [11:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] r;} mcc_row_type;
  localparam int P [4] = '{16, 32, 80, 200};
  // Only the fast tone is shortened; the other two keep their real half periods.
  localparam int TONE_FAST = 4;
  mcc_row_type rows [5] = '{'{CCSR_ADDR, 8'hFF, 8'hFE, RESP_OKAY},
    '{BEEP_ADDR, 8'h03, 8'h03, RESP_OKAY}, '{EVT_MASK_ADDR, 8'h02, 8'h02, RESP_OKAY},
    '{12'h000, 8'h55, 8'h00, RESP_SLVERR}, '{CCSR_ADDR, 8'h00, 8'h00, RESP_OKAY}};
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic [ADDR_WIDTH-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hF;
  logic [2:0] prot = 3'h0;
  logic haltReq = 1'h0, wakeReq = 1'h0, waitMode = 1'h0, cpuIntMask = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, haltInstruction, haltWakeup, irq;
  logic cpuClockEnable, activeHaltMode, fullHaltMode, timerIrq;
  logic clockOutPinOut, clockOutPinOe, tonePinOut, tonePinOe;
  logic [1:0] bresp, rresp, rr;
  logic [31:0] rdata;
  logic [7:0] rv;
  int miscompares = 0, check_count = 0, cyc = 0, t0 = 0, n, t;
  mcc_main_clock #(.TB_COUNT_0(16), .TB_COUNT_1(32), .TB_COUNT_2(80), .TB_COUNT_3(200),
    .TONE_COUNT_HIGH(TONE_FAST)) u_mcc_main_clock (
    .clk, .rst, .awaddr, .awprot(prot), .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arprot(prot), .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .haltInstruction, .haltWakeup, .waitMode, .cpuIntMask,
    .cpuClockEnable, .activeHaltMode, .fullHaltMode, .timerIrq, .irq, .clockOutPinOut,
    .clockOutPinOe, .tonePinOut, .tonePinOe);
  mcc_cpu_model u_mcc_cpu_model (.clk, .rst, .haltReq, .wakeReq, .haltInstruction,
    .haltWakeup);
  initial forever #10 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    rr = bresp;
    bready <= 1'h0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge clk); while (!rvalid);
    rv = rdata[7:0];
    rr = rresp;
    rready <= 1'h0;
  endtask : rd
  // Reading clears the flag first, so the next rise is a fresh period end.
  task automatic nextFlag(output int g);
    rd(CCSR_ADDR);
    while (!timerIrq) @(posedge clk);
    g = cyc - t0;
    t0 = cyc;
  endtask : nextFlag
  task automatic count32(output int c, output int tg);
    logic last;
    c = 0;
    tg = 0;
    last = clockOutPinOut;
    repeat (32) begin
      @(posedge clk);
      c += cpuClockEnable;
      tg += (clockOutPinOut !== last);
      last = clockOutPinOut;
    end
  endtask : count32
  task automatic toneGap(output int g);
    logic last;
    last = tonePinOut;
    do @(posedge clk); while (tonePinOut === last);
    last = tonePinOut;
    g = 0;
    do begin
      @(posedge clk);
      g++;
    end while (tonePinOut === last && g < 2 * TONE_HALF_LOW);
  endtask : toneGap
  task automatic resetCheck;
    rd(CCSR_ADDR);
    chk(rv, 8'h00);
    rd(BEEP_ADDR);
    chk(rv, 8'h00);
  endtask : resetCheck
  task automatic final_report;
    if (miscompares == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    resetCheck();
    foreach (rows[i]) begin
      prot <= 3'(i);
      wr(rows[i].a, rows[i].d);
      chk(rr, rows[i].r);
      rd(rows[i].a);
      chk(rr, rows[i].r);
      chk(rv & (rows[i].a == CCSR_ADDR ? 8'hFE : 8'hFF), rows[i].e);
    end
    // Clock out on, normal speed first, then each slow divider.
    wr(CCSR_ADDR, 8'h80);
    count32(n, t);
    chk(n, 32);
    chk(t, 32);
    foreach (P[k]) begin
      wr(CCSR_ADDR, {1'h1, k[1:0], 5'h10});
      repeat (16) @(posedge clk);
      count32(n, t);
      chk(n, 32 >> (k + 1));
      chk(t, 32 >> (k + 1));
      chk(clockOutPinOe, 1'h1);
    end
    wr(CCSR_ADDR, 8'h00);
    chk(clockOutPinOe, 1'h0);
    for (int s = 1; s < 4; s++) begin
      wr(BEEP_ADDR, s[7:0]);
      toneGap(n);
      chk(n, s == 1 ? TONE_FAST : s == 2 ? TONE_HALF_MID : TONE_HALF_LOW);
      chk(tonePinOe, 1'h1);
    end
    wr(BEEP_ADDR, 8'h00);
    chk(tonePinOe, 1'h0);
    // A write without its low byte strobe is answered but must change nothing.
    wstrb <= 4'h0;
    wr(BEEP_ADDR, 8'h01);
    wstrb <= 4'hF;
    chk(rr, RESP_OKAY);
    chk(tonePinOe, 1'h0);
    // The time base must keep its pace while the core waits.
    waitMode <= 1'h1;
    wr(CCSR_ADDR, 8'h02);
    nextFlag(n);
    foreach (P[k]) begin
      wr(CCSR_ADDR, {4'h0, k[1:0], 2'h2});
      nextFlag(n);
      chk(n, P[k > 0 ? k - 1 : 0]);
      nextFlag(n);
      chk(n, P[k]);
    end
    waitMode <= 1'h0;
    cpuIntMask <= 1'h1;
    @(posedge clk);
    #1 chk(timerIrq, 1'h0);
    wr(EVT_MASK_ADDR, 8'h01);
    chk(irq, 1'h1);
    wr(EVT_STATUS_ADDR, 8'h01);
    chk(irq, 1'h0);
    rd(CCSR_ADDR);
    chk(rv[0], 1'h1);
    rd(CCSR_ADDR);
    chk(rv[0], 1'h0);
    cpuIntMask <= 1'h0;
    wr(EVT_MASK_ADDR, 8'h00);
    // Active halt with the long period; writes during it must be ignored.
    wr(BEEP_ADDR, 8'h01);
    wr(CCSR_ADDR, 8'h8E);
    rd(CCSR_ADDR);
    haltReq <= 1'h1;
    @(posedge clk);
    haltReq <= 1'h0;
    repeat (3) @(posedge clk);
    chk(activeHaltMode, 1'h1);
    wr(BEEP_ADDR, 8'h02);
    toneGap(n);
    chk(n, TONE_FAST);
    rd(BEEP_ADDR);
    chk(rv, 8'h01);
    n = 0;
    while (activeHaltMode && n < 300) begin
      @(posedge clk);
      n++;
    end
    chk(activeHaltMode, 1'h0);
    wr(CCSR_ADDR, 8'h80);
    haltReq <= 1'h1;
    @(posedge clk);
    haltReq <= 1'h0;
    repeat (100) @(posedge clk);
    chk(fullHaltMode, 1'h1);
    wakeReq <= 1'h1;
    @(posedge clk);
    wakeReq <= 1'h0;
    repeat (3) @(posedge clk);
    chk(fullHaltMode, 1'h0);
    wr(BEEP_ADDR, 8'h03);
    rst <= 1'h1;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    resetCheck();
    final_report();
  end
endmodule : tb_mcc_main_clock
bind mcc_main_clock mcc_main_clock_properties u_mcc_main_clock_properties (.clk, .rst,
  .arvalid, .arready, .rvalid, .rready, .rdata, .bvalid, .bready, .bresp, .haltInstruction,
  .haltWakeup, .cpuClockEnable, .activeHaltMode, .fullHaltMode, .timerIrq, .clockOutPinOut);
